// *** lfm_pkg.sv ***
package lfm_pkg;

   // ***********************************************************
   // register offsets on the control interface
   // ***********************************************************
   localparam logic [7:0] LFM_REG4_LOW_POWER_ADDR  = 8'hd3;
   localparam logic [7:0] LFM_SUPPLY_FAULT_MASKS_ADDR = 8'hd7;
   localparam logic [7:0] LFM_BANDGAP_CONTROL_ADDR = 8'hd8;
   localparam logic [7:0] LFM_OSCILLATOR_CONTROL_ADDR     = 8'hd9;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int LFM_BEHAV_LSB   = 12;
   localparam int LFM_SOURCE_LSB  = 8;
   localparam int LFM_IMAGE_LSB   = 0;
   localparam int LFM_LS_MASK_BIT = 15;
   localparam int LFM_REG_MASK_LSB  = 8;
   localparam int LFM_BUCK_MASK_LSB = 0;
   localparam int LFM_FUSE_EN_BIT = 15;

   // ***********************************************************
   // reset values
   // ***********************************************************
   localparam logic [1:0]  LFM_BEHAV_RST  = 2'h0;
   localparam logic [1:0]  LFM_SOURCE_RST = 2'h0;
   localparam logic [4:0]  LFM_IMAGE_RST  = 5'h1c;
   localparam logic [8:0]  LFM_MASK_RST   = 9'h000;
   localparam logic        LFM_FUSE_RST   = 1'b0;

   // ***********************************************************
   // image voltage code to millivolts
   // ***********************************************************
   localparam logic [11:0] LFM_LOW_BASE_MV  = 12'h384; // 900 mV
   localparam logic [11:0] LFM_LOW_STEP_MV  = 12'h032; // 50 mV
   localparam logic [11:0] LFM_HIGH_BASE_MV = 12'h708; // 1800 mV
   localparam logic [11:0] LFM_HIGH_STEP_MV = 12'h064; // 100 mV

   typedef enum logic [1:0] {
      LFM_BEHAV_IMAGE,
      LFM_BEHAV_OFF,
      LFM_BEHAV_RSVD2,
      LFM_BEHAV_RSVD3
   } lfm_behav_t;

   typedef enum logic [1:0] {
      LFM_SRC_SW,
      LFM_SRC_LP1,
      LFM_SRC_LP2,
      LFM_SRC_LP3
   } lfm_source_t;

   // register access request from the control interface
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [15:0] wdata;
   } lfm_reg_req_t;

   // fault inputs, same order as the mask bits they meet
   typedef struct packed {
      logic       limit_switch;
      logic [3:0] reg_fault;
      logic [3:0] buck_fault;
   } lfm_faults_t;

   function automatic logic [11:0] lfm_image_mv(input logic [4:0] code);
      logic [11:0] steps;
      steps = {8'h00, code[3:0]};
      if (code[4]) begin
         lfm_image_mv = 12'(LFM_HIGH_BASE_MV + 12'(steps * LFM_HIGH_STEP_MV));
      end else begin
         lfm_image_mv = 12'(LFM_LOW_BASE_MV + 12'(steps * LFM_LOW_STEP_MV));
      end
   endfunction

endpackage

// *** lfm_fuse_ctl.sv ***
`timescale 1ns/100ps
// ***********************************************************
// one fuse-current enable bit with its load pulse
// ***********************************************************
module lfm_fuse_ctl
   import lfm_pkg::*;
(
   input  wire logic sys_clk_in,
   input  wire logic rst_in,
   input  wire logic wr_en_in,
   input  wire logic wr_bit_in,
   output logic      current_en_out,
   output logic      load_pulse_out
);

   logic next_current_en;
   logic next_load_pulse;

   // load fires on the falling edge of the enable, i.e. the set-then-clear
   always_comb begin
      next_current_en = current_en_out;
      next_load_pulse = 1'b0;
      if (wr_en_in) begin
         next_current_en = wr_bit_in;
         next_load_pulse = current_en_out & ~wr_bit_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         current_en_out <= LFM_FUSE_RST;
         load_pulse_out <= 1'b0;
      end else begin
         current_en_out <= next_current_en;
         load_pulse_out <= next_load_pulse;
      end
   end

   AST_FUSE_LOAD_ON_CLEAR: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL10]
      load_pulse_out |-> $past(current_en_out, 1) && !current_en_out)
      else $error("fuse load pulse without a set-then-clear");

   AST_FUSE_CURRENT_HELD: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL9]
      (current_en_out && !wr_en_in) |=> current_en_out)
      else $error("fuse current dropped without a write");

endmodule

// *** lfm_regs.sv ***
`timescale 1ns/100ps
// Contract
// (RL1) While hibernating, behaviour 00 selects the image voltage and 01 turns the output off.
// (RL2) Source 00 takes the software hibernate bit, 01..11 take low-power inputs one to three.
// (RL3) Image code 0..15 gives 0.9V to 1.65V in 50mV steps, 16..31 gives 1.8V to 3.3V in 100mV.
// (RL4) Reset brings behaviour and source to 00 and the image code to 11100, fixed in logic.
// (RL5) Mask bit 15 decides whether the limit-switch fault reaches the supply-fault output.
// (RL6) Mask bits 8 to 11 gate the faults of regulators one to four.
// (RL7) Mask bits 0 to 3 gate the faults of converters one to four.
// (RL8) A mask bit at 0 passes its fault, at 1 blocks it, and all masks reset to 0.
// (RL9) Software holds the bandgap fuse-current bit set through any fuse programming.
// (RL10) Writing the bandgap fuse-current bit 1 then 0 loads the fused trim value.
// (RL11) The oscillator fuse-current bit works alike and takes writes only when unlocked.
// (RL12) The active-low supply-fault output is low while any unmasked fault is present.
module lfm_regs
   import lfm_pkg::*;
(
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   input  wire lfm_reg_req_t reg_req_in,
   output logic [15:0]       reg_rdata_out,
   output logic              reg_rvalid_out,
   input  wire logic         sw_hibernate_in,
   input  wire logic         lowpower_in_1,
   input  wire logic         lowpower_in_2,
   input  wire logic         lowpower_in_3,
   input  wire logic         security_unlocked_in,
   input  wire lfm_faults_t  faults_in,
   output logic              reg4_hibernating_out,
   output logic              reg4_image_sel_out,
   output logic              reg4_off_out,
   output logic [11:0]       reg4_image_mv_out,
   output logic              supply_fault_n_out,
   output logic              bandgap_fuse_current_out,
   output logic              bandgap_fuse_load_out,
   output logic              osc_fuse_current_out,
   output logic              osc_fuse_load_out
);

   // ***********************************************************
   // register state
   // ***********************************************************
   lfm_behav_t  reg4_sleep_behaviour;
   lfm_source_t reg4_sleep_source;
   logic [4:0]  reg4_image_voltage;
   lfm_faults_t fault_mask;
   lfm_behav_t  next_behaviour;
   lfm_source_t next_source;
   logic [4:0]  next_image;
   lfm_faults_t next_mask;
   logic        wr_lowpower;
   logic        wr_masks;
   logic        wr_bandgap;
   logic        wr_osc;

   // address decode; unmapped writes are simply dropped
   always_comb begin
      wr_lowpower = reg_req_in.wr && (reg_req_in.addr == LFM_REG4_LOW_POWER_ADDR);
      wr_masks    = reg_req_in.wr && (reg_req_in.addr == LFM_SUPPLY_FAULT_MASKS_ADDR);
      wr_bandgap  = reg_req_in.wr && (reg_req_in.addr == LFM_BANDGAP_CONTROL_ADDR);
      wr_osc      = reg_req_in.wr && (reg_req_in.addr == LFM_OSCILLATOR_CONTROL_ADDR)
                    && security_unlocked_in; // [RL11]
   end

   // next values of the stored fields
   always_comb begin
      next_behaviour = reg4_sleep_behaviour;
      next_source    = reg4_sleep_source;
      next_image     = reg4_image_voltage;
      next_mask      = fault_mask;
      if (wr_lowpower) begin
         next_behaviour = lfm_behav_t'(reg_req_in.wdata[LFM_BEHAV_LSB +: 2]);
         next_source    = lfm_source_t'(reg_req_in.wdata[LFM_SOURCE_LSB +: 2]);
         next_image     = reg_req_in.wdata[LFM_IMAGE_LSB +: 5];
      end
      if (wr_masks) begin
         next_mask.limit_switch = reg_req_in.wdata[LFM_LS_MASK_BIT];     // [RL5]
         next_mask.reg_fault    = reg_req_in.wdata[LFM_REG_MASK_LSB +: 4]; // [RL6]
         next_mask.buck_fault   = reg_req_in.wdata[LFM_BUCK_MASK_LSB +: 4]; // [RL7]
      end
   end

   // defaults are constants in logic, nothing is loaded from fuses
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         reg4_sleep_behaviour <= lfm_behav_t'(LFM_BEHAV_RST);  // [RL4]
         reg4_sleep_source    <= lfm_source_t'(LFM_SOURCE_RST); // [RL4]
         reg4_image_voltage   <= LFM_IMAGE_RST;                // [RL4]
         fault_mask           <= lfm_faults_t'(LFM_MASK_RST);   // [RL8]
      end else begin
         reg4_sleep_behaviour <= next_behaviour;
         reg4_sleep_source    <= next_source;
         reg4_image_voltage   <= next_image;
         fault_mask           <= next_mask;
      end
   end

   // ***********************************************************
   // fuse-current enables
   // ***********************************************************
   lfm_fuse_ctl u_bandgap_fuse (
      .sys_clk_in     (sys_clk_in),
      .rst_in         (rst_in),
      .wr_en_in       (wr_bandgap),
      .wr_bit_in      (reg_req_in.wdata[LFM_FUSE_EN_BIT]),
      .current_en_out (bandgap_fuse_current_out),
      .load_pulse_out (bandgap_fuse_load_out)
   );

   lfm_fuse_ctl u_osc_fuse (
      .sys_clk_in     (sys_clk_in),
      .rst_in         (rst_in),
      .wr_en_in       (wr_osc),
      .wr_bit_in      (reg_req_in.wdata[LFM_FUSE_EN_BIT]),
      .current_en_out (osc_fuse_current_out),
      .load_pulse_out (osc_fuse_load_out)
   );

   // ***********************************************************
   // readback, one cycle after the read strobe
   // ***********************************************************
   logic [15:0] next_rdata;
   logic        next_rvalid;

   // reserved bits and unmapped offsets read as zero
   always_comb begin
      next_rdata  = 16'h0000;
      next_rvalid = reg_req_in.rd;
      if (reg_req_in.rd) begin
         unique case (reg_req_in.addr)
            LFM_REG4_LOW_POWER_ADDR: begin
               next_rdata[LFM_BEHAV_LSB +: 2]  = reg4_sleep_behaviour;
               next_rdata[LFM_SOURCE_LSB +: 2] = reg4_sleep_source;
               next_rdata[LFM_IMAGE_LSB +: 5]  = reg4_image_voltage;
            end
            LFM_SUPPLY_FAULT_MASKS_ADDR: begin
               next_rdata[LFM_LS_MASK_BIT]         = fault_mask.limit_switch;
               next_rdata[LFM_REG_MASK_LSB +: 4]   = fault_mask.reg_fault;
               next_rdata[LFM_BUCK_MASK_LSB +: 4]  = fault_mask.buck_fault;
            end
            LFM_BANDGAP_CONTROL_ADDR: begin
               next_rdata[LFM_FUSE_EN_BIT] = bandgap_fuse_current_out;
            end
            LFM_OSCILLATOR_CONTROL_ADDR: begin
               next_rdata[LFM_FUSE_EN_BIT] = osc_fuse_current_out;
            end
            default: begin
               next_rdata = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         reg_rdata_out  <= 16'h0000;
         reg_rvalid_out <= 1'b0;
      end else begin
         reg_rdata_out  <= next_rdata;
         reg_rvalid_out <= next_rvalid;
      end
   end

   // ***********************************************************
   // hibernate and supply-fault outputs
   // ***********************************************************
   logic        hib_trigger;
   logic        next_image_sel;
   logic        next_off;
   logic        next_fault_n;
   logic [11:0] next_mv;

   // reserved behaviour codes leave the regulator in normal operation
   always_comb begin
      unique case (reg4_sleep_source) // [RL2]
         LFM_SRC_SW:  hib_trigger = sw_hibernate_in;
         LFM_SRC_LP1: hib_trigger = lowpower_in_1;
         LFM_SRC_LP2: hib_trigger = lowpower_in_2;
         LFM_SRC_LP3: hib_trigger = lowpower_in_3;
      endcase
      next_image_sel = hib_trigger && (reg4_sleep_behaviour == LFM_BEHAV_IMAGE); // [RL1]
      next_off       = hib_trigger && (reg4_sleep_behaviour == LFM_BEHAV_OFF);   // [RL1]
      next_mv        = lfm_image_mv(reg4_image_voltage);                        // [RL3]
      next_fault_n   = ~|(faults_in & ~fault_mask);                        // [RL8] [RL12]
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         reg4_hibernating_out <= 1'b0;
         reg4_image_sel_out   <= 1'b0;
         reg4_off_out         <= 1'b0;
         reg4_image_mv_out    <= 12'h000;
         supply_fault_n_out   <= 1'b1;
      end else begin
         reg4_hibernating_out <= hib_trigger;
         reg4_image_sel_out   <= next_image_sel;
         reg4_off_out         <= next_off;
         reg4_image_mv_out    <= next_mv;
         supply_fault_n_out   <= next_fault_n;
      end
   end

   // ***********************************************************
   // checks
   // ***********************************************************
   AST_HIB_OFF: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL1]
      reg4_off_out |-> $past(reg4_sleep_behaviour) == LFM_BEHAV_OFF && reg4_hibernating_out)
      else $error("regulator off without off behaviour");

   AST_HIB_SRC_LP3: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL2]
      (reg4_sleep_source == LFM_SRC_LP3) |=> reg4_hibernating_out == $past(lowpower_in_3))
      else $error("hibernate not following third low-power input");

   AST_IMAGE_MV: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL3]
      ($past(reg4_image_voltage) == 5'h1f) |-> reg4_image_mv_out == 12'hce4)
      else $error("top image code is not 3300 mV");

   // looks one edge ahead of reset so that the undefined state before time zero is never judged
   AST_RESET_DEFAULTS: assert property (@(posedge sys_clk_in) // [RL4]
      rst_in |=> reg4_image_voltage == 5'h1c && reg4_sleep_source == LFM_SRC_SW
                 && reg4_sleep_behaviour == LFM_BEHAV_IMAGE && fault_mask == '0)
      else $error("low-power fields not at defaults after reset");

   AST_LS_MASK: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL5]
      // the output still shows its reset level on the first edge after release
      (!$past(rst_in) && $past(faults_in.limit_switch) && !$past(fault_mask.limit_switch))
         |-> !supply_fault_n_out)
      else $error("unmasked limit-switch fault did not reach output");

   AST_MASK_BLOCKS: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL8]
      ($past(faults_in) == $past(fault_mask)) |-> supply_fault_n_out)
      else $error("fully masked faults still drove output low");

   AST_OSC_LOCKED: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL11]
      !security_unlocked_in |=> $stable(osc_fuse_current_out))
      else $error("oscillator fuse bit changed while locked");

   AST_FAULT_OUT: assert property (@(posedge sys_clk_in) disable iff (rst_in) // [RL12]
      (!$past(rst_in) && $past(faults_in.reg_fault[3]) && !$past(fault_mask.reg_fault[3]))
         |-> !supply_fault_n_out)
      else $error("unmasked regulator four fault missed");

endmodule

// *** lfm_tb.sv ***
`timescale 1ns/100ps
module testbench;
   import lfm_pkg::*;
   // ***********************************************************
   // stimulus, observed outputs and the bench model
   // ***********************************************************
   logic         sys_clk_in = 1'b0;
   logic         rst_in     = 1'b1;
   lfm_reg_req_t req        = '0;
   lfm_faults_t  flt        = '0;
   logic         sw = 1'b0, lp1 = 1'b0, lp2 = 1'b0, lp3 = 1'b0, unl = 1'b0;
   logic [15:0]  rdata;
   logic [11:0]  mv;
   logic         rvalid, hib, isel, off, fault_n, bg_cur, bg_ld, os_cur, os_ld;
   int           mismatches = 0, samples_checked = 0, ld_seen = 0, ld_exp = 0;
   logic [15:0]  m_reg [4];
   // writable bits of d3, d7, d8, d9; the rest read back as zero
   const logic [15:0] keep [4] = '{16'h331f, 16'h8f0f, 16'h8000, 16'h8000};
   const logic [7:0]  atab [5] = '{8'hd3, 8'hd7, 8'hd8, 8'hd9, 8'h55};

   lfm_regs dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .reg_req_in(req),
      .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .sw_hibernate_in(sw),
      .lowpower_in_1(lp1), .lowpower_in_2(lp2), .lowpower_in_3(lp3),
      .security_unlocked_in(unl), .faults_in(flt), .reg4_hibernating_out(hib),
      .reg4_image_sel_out(isel), .reg4_off_out(off), .reg4_image_mv_out(mv),
      .supply_fault_n_out(fault_n), .bandgap_fuse_current_out(bg_cur),
      .bandgap_fuse_load_out(bg_ld), .osc_fuse_current_out(os_cur),
      .osc_fuse_load_out(os_ld));

   always #25 sys_clk_in = ~sys_clk_in;

   // load pulses are counted mid-cycle, so a missing or doubled pulse both show
   always @(negedge sys_clk_in) begin
      if (!rst_in) begin
         ld_seen += int'(bg_ld) + int'(os_ld);
      end
   end

   // ***********************************************************
   // bus tasks and comparisons
   // ***********************************************************
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic int idx(input logic [7:0] a);
      for (int k = 0; k < 4; k++) begin
         if (atab[k] == a) return k;
      end
      return -1;
   endfunction

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      int i;
      i = idx(a);
      @(negedge sys_clk_in);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      // the oscillator word is locked unless the key is open in the write cycle
      if (i >= 0 && !(i == 3 && !unl)) begin
         if (i >= 2 && m_reg[i][15] && !d[15]) ld_exp++;
         m_reg[i] = d & keep[i];
      end
      @(negedge sys_clk_in);
      req.wr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      int i;
      i = idx(a);
      @(negedge sys_clk_in);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge sys_clk_in);
      req.rd = 1'b0;
      chk("rvalid", 16'h1, {15'h0, rvalid});
      chk("rdata", (i < 0) ? 16'h0 : m_reg[i], rdata);
   endtask

   // outputs are compared once settled, so latency choices do not matter
   task automatic outs();
      logic       trig;
      logic       fn;
      logic [1:0] s, b;
      logic [4:0] c;
      int         emv;
      repeat (2) @(negedge sys_clk_in);
      s = m_reg[0][9:8];
      b = m_reg[0][13:12];
      c = m_reg[0][4:0];
      trig = (s == 0) ? sw : (s == 1) ? lp1 : (s == 2) ? lp2 : lp3;
      emv = c[4] ? 1800 + 100 * int'(c[3:0]) : 900 + 50 * int'(c[3:0]);
      fn = ~|(flt & ~{m_reg[1][15], m_reg[1][11:8], m_reg[1][3:0]});
      chk("hibernating", {15'h0, trig}, {15'h0, hib});
      chk("image_sel", {15'h0, trig && b == 0}, {15'h0, isel});
      chk("off", {15'h0, trig && b == 1}, {15'h0, off});
      chk("image_mv", 16'(emv), {4'h0, mv});
      chk("fault_n", {15'h0, fn}, {15'h0, fault_n});
      chk("fuse_current", {14'h0, m_reg[3][15], m_reg[2][15]}, {14'h0, os_cur, bg_cur});
      chk("fuse_loads", 16'(ld_exp), 16'(ld_seen));
   endtask

   task automatic do_reset();
      rst_in = 1'b1;
      m_reg = '{16'h001c, 16'h0, 16'h0, 16'h0};
      repeat (12) @(negedge sys_clk_in);
      rst_in = 1'b0;
      foreach (atab[k]) rd(atab[k]);
      outs();
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge sys_clk_in);
      mismatches++;
      results();
   end

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial begin
      void'($urandom(32'h5e95));
      do_reset();
      $display("test reset done");
      // every source and behaviour code, trigger high then low
      for (int s = 0; s < 4; s++) for (int b = 0; b < 4; b++) for (int t = 0; t < 2; t++) begin
         wr(8'hd3, {2'h0, 2'(b), 2'h0, 2'(s), 3'h0, 5'(s * 8 + b)});
         {sw, lp1, lp2, lp3} = (4'h8 >> s) ^ {4{t[0]}};
         outs();
      end
      foreach (atab[k]) begin
         wr(8'hd3, {11'h0, 5'(k == 0 ? 0 : k == 1 ? 15 : k == 2 ? 16 : 31)});
         outs();
      end
      $display("test sleep control done");
      // each fault alone: passes, blocked by its own bit, passes with all others set
      for (int i = 0; i < 9; i++) begin
         flt = lfm_faults_t'(9'h1 << i);
         wr(8'hd7, 16'h0);
         outs();
         wr(8'hd7, 16'h1 << ((i < 4) ? i : (i < 8) ? i + 4 : 15));
         outs();
         wr(8'hd7, ~(16'h1 << ((i < 4) ? i : (i < 8) ? i + 4 : 15)));
         outs();
      end
      $display("test fault masks done");
      // locked write, set and clear pulses, and a clear over a clear
      unl = 1'b0;
      wr(8'hd9, 16'h8000);
      outs();
      unl = 1'b1;
      foreach (atab[k]) begin
         wr(8'hd9, {~k[0], 15'h0});
         wr(8'hd8, {~k[0], 15'h7fff});
         outs();
      end
      wr(8'hd8, 16'h0000);
      wr(8'hd8, 16'h0000);
      outs();
      $display("test fuse control done");
      for (int n = 0; n < 150; n++) begin
         unl = 1'($urandom);
         {sw, lp1, lp2, lp3} = 4'($urandom);
         flt = lfm_faults_t'(9'($urandom));
         wr(atab[$urandom % 5], 16'($urandom));
         outs();
         rd(atab[$urandom % 5]);
      end
      $display("test random traffic done");
      do_reset();
      $display("test second reset done");
      results();
   end
endmodule
